/* File: hw/pcm_port_cd_mux.sv */
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module pcm_port_cd_mux (
  input  wire logic                  sys_clk_i,
  input  wire logic                  resetn_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [7:0]            paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic                       pready_o,
  output logic [31:0]                prdata_o,
  output logic                       pslverr_o,
  input  wire logic [7:0]            porta_in_i,
  input  wire logic [7:0]            portb_in_i,
  input  wire logic [6:0]            portc_in_i,
  input  wire logic [3:0]            portd_in_i,
  output logic [6:0]                 portc_out_o,
  output logic [6:0]                 portc_oe_n_o,
  output logic [6:0]                 portc_analog_o,
  output logic [3:0]                 portd_out_o,
  output logic [3:0]                 portd_oe_n_o,
  output logic [3:0]                 portd_analog_o,
  input  wire pcm_pkg::pcm_peri_out_t peri_out_i,
  input  wire logic [6:0]            lcd_portc_i,
  input  wire logic [3:0]            lcd_portd_i,
  output pcm_pkg::pcm_peri_in_t      peri_in_o,
  output logic                       wake_o
);

  pcm_pkg::pcm_state_t st;
  pcm_pkg::pcm_state_t next_st;

  logic       setup;
  logic       wr;
  logic [7:0] pc_low_eff;
  logic [7:0] src_eff;
  logic [1:0] bop_port;
  logic [2:0] bop_bit;
  logic [7:0] rmw_word;

  // address phase decode; a write lands at the access edge, where pready is already high
  assign setup = psel_i && !penable_i;
  assign wr    = psel_i && penable_i && pwrite_i && st.pready;

  // reduced variant masks unimplemented bits at the read side and in the mux
  assign pc_low_eff = st.ctrl[pcm_pkg::CTRL_REDUCED] ? (st.pc_low & pcm_pkg::PC_LOW_RMASK) : st.pc_low;
  assign src_eff    = st.ctrl[pcm_pkg::CTRL_REDUCED] ? (st.src_sel & pcm_pkg::SRC_RMASK) : st.src_sel;

  // bit operation fields
  assign bop_port = pwdata_i[1:0];
  assign bop_bit  = pwdata_i[pcm_pkg::BOP_BIT_LSB +: 3];

  // whole-port read, modify one bit, then write the whole word back
  always_comb begin
    rmw_word = pwdata_i[pcm_pkg::BOP_DIR] ? st.dir[bop_port] : st.data[bop_port];
    rmw_word[bop_bit] = pwdata_i[pcm_pkg::BOP_VAL];
  end

  // next-state logic: register writes, read mux, pin mux and wake detect
  always_comb begin
    logic [1:0] fc;
    logic [1:0] fd;
    logic       g;
    fc = 2'h0;
    fd = 2'h0;
    g  = 1'b0;
    next_st = st;
    next_st.pready = setup;
    // register writes
    if (wr) begin
      if (paddr_i == pcm_pkg::ADDR_PC_LOW) begin
        next_st.pc_low = pwdata_i[7:0];
      end else if (paddr_i == pcm_pkg::ADDR_PC_HIGH) begin
        next_st.pc_high = pwdata_i[7:0] & pcm_pkg::PC_HIGH_MASK;
      end else if (paddr_i == pcm_pkg::ADDR_PD_FUNC) begin
        next_st.pd_func = pwdata_i[7:0];
      end else if (paddr_i == pcm_pkg::ADDR_SRC_SEL) begin
        next_st.src_sel = pwdata_i[7:0] & pcm_pkg::SRC_MASK;
      end else if (paddr_i == pcm_pkg::ADDR_PA_DATA) begin
        next_st.data[0] = pwdata_i[7:0];
      end else if (paddr_i == pcm_pkg::ADDR_PA_DIR) begin
        next_st.dir[0] = pwdata_i[7:0];
      end else if (paddr_i == pcm_pkg::ADDR_PB_DATA) begin
        next_st.data[1] = pwdata_i[7:0];
      end else if (paddr_i == pcm_pkg::ADDR_PB_DIR) begin
        next_st.dir[1] = pwdata_i[7:0];
      end else if (paddr_i == pcm_pkg::ADDR_PC_DATA) begin
        next_st.data[2] = pwdata_i[7:0];
      end else if (paddr_i == pcm_pkg::ADDR_PC_DIR) begin
        next_st.dir[2] = pwdata_i[7:0];
      end else if (paddr_i == pcm_pkg::ADDR_PD_DATA) begin
        next_st.data[3] = pwdata_i[7:0];
      end else if (paddr_i == pcm_pkg::ADDR_PD_DIR) begin
        next_st.dir[3] = pwdata_i[7:0];
      end else if (paddr_i == pcm_pkg::ADDR_BIT_OP) begin
        if (pwdata_i[pcm_pkg::BOP_DIR]) begin
          next_st.dir[bop_port] = rmw_word;
        end else begin
          next_st.data[bop_port] = rmw_word;
        end
      end else if (paddr_i == pcm_pkg::ADDR_WAKE_EN) begin
        next_st.wake_en = pwdata_i[7:0];
      end else if (paddr_i == pcm_pkg::ADDR_CTRL) begin
        next_st.ctrl = pwdata_i[1:0];
      end else if (paddr_i == pcm_pkg::ADDR_STATUS) begin
        next_st.wake = st.wake & ~pwdata_i[0];
      end
    end
    // read data is captured in the setup cycle and held through access
    if (setup) begin
      next_st.prdata = 32'h0000_0000;
      if (paddr_i == pcm_pkg::ADDR_PC_LOW) begin
        next_st.prdata[7:0] = pc_low_eff;
      end else if (paddr_i == pcm_pkg::ADDR_PC_HIGH) begin
        next_st.prdata[7:0] = st.pc_high;
      end else if (paddr_i == pcm_pkg::ADDR_PD_FUNC) begin
        next_st.prdata[7:0] = st.pd_func;
      end else if (paddr_i == pcm_pkg::ADDR_SRC_SEL) begin
        next_st.prdata[7:0] = src_eff;
      end else if (paddr_i == pcm_pkg::ADDR_PA_DATA) begin
        next_st.prdata[7:0] = st.data[0];
      end else if (paddr_i == pcm_pkg::ADDR_PA_DIR) begin
        next_st.prdata[7:0] = st.dir[0];
      end else if (paddr_i == pcm_pkg::ADDR_PB_DATA) begin
        next_st.prdata[7:0] = st.data[1];
      end else if (paddr_i == pcm_pkg::ADDR_PB_DIR) begin
        next_st.prdata[7:0] = st.dir[1];
      end else if (paddr_i == pcm_pkg::ADDR_PC_DATA) begin
        next_st.prdata[7:0] = st.data[2];
      end else if (paddr_i == pcm_pkg::ADDR_PC_DIR) begin
        next_st.prdata[7:0] = st.dir[2];
      end else if (paddr_i == pcm_pkg::ADDR_PD_DATA) begin
        next_st.prdata[7:0] = st.data[3];
      end else if (paddr_i == pcm_pkg::ADDR_PD_DIR) begin
        next_st.prdata[7:0] = st.dir[3];
      end else if (paddr_i == pcm_pkg::ADDR_WAKE_EN) begin
        next_st.prdata[7:0] = st.wake_en;
      end else if (paddr_i == pcm_pkg::ADDR_CTRL) begin
        next_st.prdata[1:0] = st.ctrl;
      end else if (paddr_i == pcm_pkg::ADDR_STATUS) begin
        next_st.prdata[0] = st.wake;
      end
    end

    // port c pin drivers; gpio drives data when direction bit is low
    for (int i = 0; i < 7; i++) begin
      fc = (i < 4) ? pc_low_eff[2*(i%4) +: 2] : st.pc_high[2*(i%4) +: 2]; // modulo keeps both selects in range
      g = 1'b0;
      next_st.c_ana[i] = 1'b0;
      next_st.c_out[i] = st.data[2][i];
      next_st.c_oe_n[i] = st.dir[2][i];
      case (i)
        0: begin
          if (fc == pcm_pkg::FN_01) begin
            next_st.c_out[i] = peri_out_i.uart_tx;
            next_st.c_oe_n[i] = 1'b0;
          end else if (fc == pcm_pkg::FN_10) begin
            g = 1'b1;
          end else if (fc == pcm_pkg::FN_11) begin
            next_st.c_ana[i] = 1'b1;
            next_st.c_oe_n[i] = 1'b1;
          end
        end
        1: begin
          if (fc == pcm_pkg::FN_01) begin
            next_st.c_out[i] = peri_out_i.uart_tx;
            next_st.c_oe_n[i] = peri_out_i.uart_rxtx_oe_n;
          end else if (fc == pcm_pkg::FN_10) begin
            g = 1'b1;
          end else if (fc == pcm_pkg::FN_11) begin
            next_st.c_ana[i] = 1'b1;
            next_st.c_oe_n[i] = 1'b1;
          end
        end
        2, 3: begin
          if (fc == pcm_pkg::FN_10) begin
            next_st.c_out[i] = peri_out_i.serial_data_out;
            next_st.c_oe_n[i] = 1'b0;
          end else if (fc == pcm_pkg::FN_11) begin
            g = 1'b1;
          end
        end
        default: begin
          if (fc == pcm_pkg::FN_10) begin
            if (i == 4) begin
              next_st.c_out[i] = peri_out_i.serial_data_out;
              next_st.c_oe_n[i] = peri_out_i.serial_data_oe_n;
            end else if (i == 5) begin
              next_st.c_out[i] = peri_out_i.serial_clock_out;
              next_st.c_oe_n[i] = 1'b0;
            end else begin
              next_st.c_oe_n[i] = 1'b1; // chip select is an input
            end
          end else if (fc == pcm_pkg::FN_11) begin
            g = 1'b1;
          end
        end
      endcase
      if (g) begin
        next_st.c_out[i] = lcd_portc_i[i];
        next_st.c_oe_n[i] = 1'b0;
      end
    end

    // port d pin drivers
    for (int j = 0; j < 4; j++) begin
      fd = st.pd_func[2*j +: 2];
      g = 1'b0;
      next_st.d_ana[j] = 1'b0;
      next_st.d_out[j] = st.data[3][j];
      next_st.d_oe_n[j] = st.dir[3][j];
      if (j == 0) begin
        if (fd == pcm_pkg::FN_10) begin
          next_st.d_out[j] = peri_out_i.periodic_timer_out;
          next_st.d_oe_n[j] = 1'b0;
        end else if (fd == pcm_pkg::FN_11) begin
          g = 1'b1;
        end
      end else begin
        if (fd == pcm_pkg::FN_01) begin
          next_st.d_oe_n[j] = 1'b0;
          if (j == 3) begin
            next_st.d_out[j] = peri_out_i.compact_timer_out;
          end else begin
            next_st.d_out[j] = peri_out_i.uart_tx;
            if (j == 1) begin
              next_st.d_oe_n[j] = peri_out_i.uart_rxtx_oe_n;
            end
          end
        end else if (fd == pcm_pkg::FN_10) begin
          g = 1'b1;
        end else if (fd == pcm_pkg::FN_11) begin
          next_st.d_ana[j] = 1'b1;
          next_st.d_oe_n[j] = 1'b1;
        end
      end
      if (g) begin
        next_st.d_out[j] = lcd_portd_i[j];
        next_st.d_oe_n[j] = 1'b0;
      end
    end

    // input source selection; the unselected pin never reaches the input
    next_st.peri_in.ext_interrupt_1 = src_eff[pcm_pkg::SRC_IRQ1] ? porta_in_i[2] : portb_in_i[1];
    next_st.peri_in.ext_interrupt_0 = src_eff[pcm_pkg::SRC_IRQ0] ? porta_in_i[1] : portb_in_i[0];
    next_st.peri_in.serial_in       = src_eff[pcm_pkg::SRC_SDI] ? porta_in_i[3] : portc_in_i[4];
    next_st.peri_in.serial_clock_in = src_eff[pcm_pkg::SRC_SCK] ? portb_in_i[6] : portc_in_i[5];
    next_st.peri_in.spi_select_in   = src_eff[pcm_pkg::SRC_CS] ? portb_in_i[5] : portc_in_i[6];
    next_st.peri_in.uart_rx         = src_eff[pcm_pkg::SRC_RX] ? portc_in_i[1] : portd_in_i[1];

    // falling edge on an enabled port a pin while asleep; set beats clear
    next_st.pa_last = porta_in_i;
    if (st.ctrl[pcm_pkg::CTRL_SLEEP] && |(st.pa_last & ~porta_in_i & st.wake_en)) begin
      next_st.wake = 1'b1;
    end
  end

  // single state register; ports start as inputs with data high
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st         <= '0;
      st.pc_low  <= pcm_pkg::FUNC_RESET;
      st.pc_high <= pcm_pkg::FUNC_RESET;
      st.pd_func <= pcm_pkg::FUNC_RESET;
      st.src_sel <= pcm_pkg::FUNC_RESET;
      st.data    <= {4{pcm_pkg::PORT_RESET}};
      st.dir     <= {4{pcm_pkg::PORT_RESET}};
      st.pa_last <= pcm_pkg::PORT_RESET;
      st.c_oe_n  <= 7'h7F;
      st.c_out   <= 7'h7F;
      st.d_oe_n  <= 4'hF;
      st.d_out   <= 4'hF;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops; pslverr tied low
  assign pready_o       = st.pready;
  assign prdata_o       = st.prdata;
  assign pslverr_o      = 1'b0;
  assign portc_out_o    = st.c_out;
  assign portc_oe_n_o   = st.c_oe_n;
  assign portc_analog_o = st.c_ana;
  assign portd_out_o    = st.d_out;
  assign portd_oe_n_o   = st.d_oe_n;
  assign portd_analog_o = st.d_ana;
  assign peri_in_o      = st.peri_in;
  assign wake_o         = st.wake;

endmodule // pcm_port_cd_mux

/* File: inc/pcm_pkg.sv */
// Notes on behaviour
// - pc3: codes 00/01 gpio, 10 serial data out, 11 lcd com/seg 18
// - pc2: 00/01 gpio with reset pin, 10 serial data out, 11 lcd 17
// - pc1: 00 gpio, 01 uart rx/tx, 10 lcd 16, 11 crystal pin 2
// - pc0: 00 gpio, 01 uart tx, 10 lcd 15, 11 crystal pin 1
// - reduced port c low register: bits 7..6 read zero and are masked in the mux, writes still stored
// - pc6: 00/01 gpio, 10 serial chip select, 11 lcd 21
// - pc5: 00/01 gpio, 10 serial clock, 11 lcd 20
// - pc4: 00/01 gpio, 10 serial data in/out, 11 lcd 19
// - pd3: 00 gpio, 01 compact timer out, 10 lcd seg 25, 11 analog 9
// - pd2: 00 gpio, 01 uart tx, 10 lcd seg 24, 11 analog 10
// - pd1: 00 gpio, 01 uart rx/tx, 10 lcd seg 23, 11 analog 11
// - pd0: 00/01 gpio, 10 periodic timer out, 11 lcd seg 22
// - irq1 from pb1 or pa2 by bit 5; irq0 from pb0 or pa1 by bit 4
// - serial in from pc4 or pa3 by bit 3; clock from pc5 or pb6 by bit 2
// - chip select from pc6 or pb5 by bit 1; uart rx from pd1 or pc1 by bit 0
// - reduced source register uses only bits 5..4; bits 3..0 read zero but stay stored
// - reset sets all port data and direction registers to ones
// - switching to output without writing data drives the pin high
// - single-bit set or clear is read, modify, write of the whole port
// - in sleep or idle, enabled port a falling edge wakes the device
package pcm_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_PC_LOW   = 8'h00;
  localparam logic [7:0] ADDR_PC_HIGH  = 8'h04;
  localparam logic [7:0] ADDR_PD_FUNC  = 8'h08;
  localparam logic [7:0] ADDR_SRC_SEL  = 8'h0C;
  localparam logic [7:0] ADDR_PA_DATA  = 8'h10;
  localparam logic [7:0] ADDR_PA_DIR   = 8'h14;
  localparam logic [7:0] ADDR_PB_DATA  = 8'h18;
  localparam logic [7:0] ADDR_PB_DIR   = 8'h1C;
  localparam logic [7:0] ADDR_PC_DATA  = 8'h20;
  localparam logic [7:0] ADDR_PC_DIR   = 8'h24;
  localparam logic [7:0] ADDR_PD_DATA  = 8'h28;
  localparam logic [7:0] ADDR_PD_DIR   = 8'h2C;
  localparam logic [7:0] ADDR_BIT_OP   = 8'h30;
  localparam logic [7:0] ADDR_WAKE_EN  = 8'h34;
  localparam logic [7:0] ADDR_CTRL     = 8'h38;
  localparam logic [7:0] ADDR_STATUS   = 8'h3C;
  // reset values
  localparam logic [7:0] FUNC_RESET    = 8'h00;
  localparam logic [7:0] PORT_RESET    = 8'hFF;
  // masks of implemented bits
  localparam logic [7:0] PC_HIGH_MASK  = 8'h3F;
  localparam logic [7:0] PC_LOW_RMASK  = 8'h3F;
  localparam logic [7:0] SRC_MASK      = 8'h3F;
  localparam logic [7:0] SRC_RMASK     = 8'h30;
  // source select bit positions
  localparam int SRC_IRQ1 = 5;
  localparam int SRC_IRQ0 = 4;
  localparam int SRC_SDI  = 3;
  localparam int SRC_SCK  = 2;
  localparam int SRC_CS   = 1;
  localparam int SRC_RX   = 0;
  // bit-operation word: [1:0] port, [4:2] bit, [5] value, [6] 1=direction reg
  localparam int BOP_BIT_LSB = 2;
  localparam int BOP_VAL     = 5;
  localparam int BOP_DIR     = 6;
  // control bits: [0] reduced variant, [1] low power mode
  localparam int CTRL_REDUCED = 0;
  localparam int CTRL_SLEEP   = 1;
  // function codes
  localparam logic [1:0] FN_00 = 2'h0;
  localparam logic [1:0] FN_01 = 2'h1;
  localparam logic [1:0] FN_10 = 2'h2;
  localparam logic [1:0] FN_11 = 2'h3;
  // pin driver sources
  typedef enum logic [2:0] {
    PCM_SRC_GPIO = 3'h0,
    PCM_SRC_PERI = 3'h1,
    PCM_SRC_LCD  = 3'h2,
    PCM_SRC_ANA  = 3'h3,
    PCM_SRC_OSC  = 3'h4
  } pcm_src_t;
  // peripheral outputs bundled
  typedef struct packed {
    logic serial_data_out;
    logic serial_clock_out;
    logic serial_data_oe_n;
    logic uart_tx;
    logic uart_rxtx_oe_n;
    logic compact_timer_out;
    logic periodic_timer_out;
  } pcm_peri_out_t;
  // peripheral inputs chosen by the source selector
  typedef struct packed {
    logic ext_interrupt_1;
    logic ext_interrupt_0;
    logic serial_in;
    logic serial_clock_in;
    logic spi_select_in;
    logic uart_rx;
  } pcm_peri_in_t;
  // the block's whole state
  typedef struct packed {
    logic [7:0]      pc_low;
    logic [7:0]      pc_high;
    logic [7:0]      pd_func;
    logic [7:0]      src_sel;
    logic [3:0][7:0] data;
    logic [3:0][7:0] dir;
    logic [7:0]      wake_en;
    logic [1:0]      ctrl;
    logic [7:0]      pa_last;
    logic            wake;
    logic            pready;
    logic [31:0]     prdata;
    logic [6:0]      c_out;
    logic [6:0]      c_oe_n;
    logic [6:0]      c_ana;
    logic [3:0]      d_out;
    logic [3:0]      d_oe_n;
    logic [3:0]      d_ana;
    pcm_peri_in_t    peri_in;
  } pcm_state_t;
endpackage

/* File: bench/pcm_port_cd_mux_chk.sv */
`timescale 1ns/10ps
module pcm_port_cd_mux_chk (
  input wire logic                  sys_clk_i,
  input wire logic                  resetn_i,
  input wire logic                  psel_i,
  input wire logic                  penable_i,
  input wire logic                  pwrite_i,
  input wire logic [7:0]            paddr_i,
  input wire logic                  pready_o,
  input wire logic [31:0]           prdata_o,
  input wire logic                  pslverr_o,
  input wire logic [7:0]            porta_in_i,
  input wire logic [7:0]            portb_in_i,
  input wire logic [6:0]            portc_in_i,
  input wire logic [3:0]            portd_in_i,
  input wire logic [6:0]            portc_oe_n_o,
  input wire logic [6:0]            portc_analog_o,
  input wire logic [3:0]            portd_oe_n_o,
  input wire pcm_pkg::pcm_peri_in_t peri_in_o,
  input wire logic                  wake_o
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // a read in its setup cycle
  logic rd_setup;
  assign rd_setup = psel_i && !penable_i && !pwrite_i;
  ready_setup_a: assert property (psel_i && !penable_i |=> pready_o) else $error("ready missing after setup");
  ready_cause_a: assert property (pready_o |-> $past(psel_i && !penable_i) && penable_i)
    else $error("ready without a setup cycle");
  no_error_a: assert property (pslverr_o == 1'b0) else $error("slave error raised");
  upper_zero_a: assert property (pready_o |-> prdata_o[31:8] == 24'h000000) else $error("upper read bits set");
  pad_zero_a: assert property (rd_setup && (paddr_i == pcm_pkg::ADDR_SRC_SEL || paddr_i == pcm_pkg::ADDR_PC_HIGH)
    |=> prdata_o[7:6] == 2'h0) else $error("unimplemented bits read as one");
  unmapped_a: assert property (rd_setup && paddr_i > 8'h3C |=> prdata_o == 32'h00000000)
    else $error("unmapped read not zero");
  // a port c analog or crystal pin must never be driven as well
  float_a: assert property ((portc_analog_o & ~portc_oe_n_o) == 7'h00) else $error("analog pin driven");
  reset_pins_a: assert property ($rose(resetn_i) |-> portc_oe_n_o == 7'h7F && portd_oe_n_o == 4'hF)
    else $error("pins not inputs after reset");
  // with both candidate pins equal the routed input is known whichever source is chosen
  irq1_src_a: assert property ($past(resetn_i) && $past(portb_in_i[1] == porta_in_i[2])
    |-> peri_in_o.ext_interrupt_1 == $past(portb_in_i[1])) else $error("interrupt 1 source wrong");
  sdi_src_a: assert property ($past(resetn_i) && $past(portc_in_i[4] == porta_in_i[3])
    |-> peri_in_o.serial_in == $past(portc_in_i[4])) else $error("serial input source wrong");
  rx_src_a: assert property ($past(resetn_i) && $past(portd_in_i[1] == portc_in_i[1])
    |-> peri_in_o.uart_rx == $past(portd_in_i[1])) else $error("receive source wrong");
  wake_cause_a: assert property ($rose(wake_o) |-> ($past(porta_in_i, 2) & ~$past(porta_in_i, 1)) != 8'h00)
    else $error("wake without a falling pin");
  cover property (rd_setup ##1 pready_o);
  cover property ($rose(wake_o));
  cover property ($changed(peri_in_o));
endmodule // pcm_port_cd_mux_chk

bind pcm_port_cd_mux pcm_port_cd_mux_chk pcm_port_cd_mux_chk_i (
  .sys_clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pready_o, .prdata_o, .pslverr_o, .porta_in_i,
  .portb_in_i, .portc_in_i, .portd_in_i, .portc_oe_n_o, .portc_analog_o, .portd_oe_n_o, .peri_in_o, .wake_o);

/* File: bench/pcm_port_cd_mux_tb.sv */
`timescale 1ns/10ps
module pcm_port_cd_mux_tb;
  logic                   sys_clk_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, wake_o, eo;
  logic [7:0]             paddr_i, porta_in_i, portb_in_i;
  logic [31:0]            pwdata_i, prdata_o, rd;
  logic [6:0]             portc_in_i, portc_out_o, portc_oe_n_o, portc_analog_o, lcd_portc_i;
  logic [3:0]             portd_in_i, portd_out_o, portd_oe_n_o, portd_analog_o, lcd_portd_i;
  logic [10:0]            dat;
  logic [5:0]             sel;
  pcm_pkg::pcm_peri_out_t peri_out_i;
  pcm_pkg::pcm_peri_in_t  peri_in_o;
  int                     err_total, checks_done, seed, kd;
  int                     mreg [16];
  // port C pins then port D pins, so one index walks all eleven
  wire [10:0] out_all = {portd_out_o, portc_out_o};
  wire [10:0] oe_all  = {portd_oe_n_o, portc_oe_n_o};
  wire [10:0] an_all  = {portd_analog_o, portc_analog_o};
  wire [10:0] lcd_all = {lcd_portd_i, lcd_portc_i};
  // stored bits per word; bit-operation and status words are handled apart
  localparam int MASK [16] = '{8'hFF, 8'h3F, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                               8'h00, 8'hFF, 8'h03, 8'h00};
  // kind per code: 0 gpio, 1 peripheral, 2 lcd, 3 analog or crystal, 4 input only
  localparam int KIND [11][4] = '{'{0, 1, 2, 3}, '{0, 1, 2, 3}, '{0, 0, 1, 2}, '{0, 0, 1, 2}, '{0, 0, 1, 2},
                                  '{0, 0, 1, 2}, '{0, 0, 4, 2}, '{0, 0, 1, 2}, '{0, 1, 2, 3}, '{0, 1, 2, 3}, '{0, 1, 2, 3}};
  // bundle bit that drives each pin in its peripheral code
  localparam int PV [11] = '{3, 3, 6, 6, 6, 5, 0, 0, 3, 3, 1};

  pcm_port_cd_mux pcm_port_cd_mux_i (.sys_clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pready_o, .prdata_o, .pslverr_o, .porta_in_i, .portb_in_i, .portc_in_i, .portd_in_i, .portc_out_o, .portc_oe_n_o,
    .portc_analog_o, .portd_out_o, .portd_oe_n_o, .portd_analog_o, .peri_out_i, .lcd_portc_i, .lcd_portd_i,
    .peri_in_o, .wake_o);

  // free running bus clock
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one transfer; starts after an edge so back-to-back calls never clash
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 20) begin
      chk("pready", 1'b0, 1'b1);
      complete_run();
    end
  endtask

  task automatic mw(input int i, input logic [7:0] d);
    apb(1'b1, 8'(i * 4), {24'h000000, d});
    mreg[i] = d & MASK[i];
  endtask

  // reduced variant hides bits at read time but keeps them stored
  function automatic int rdexp(input int i);
    if (i == 0 && mreg[14][0]) return mreg[0] & 8'h3F;
    if (i == 3 && mreg[14][0]) return mreg[3] & 8'h30;
    return mreg[i];
  endfunction

  task automatic mr(input int i);
    apb(1'b0, 8'(i * 4), 32'h00000000);
    chk("register", rd, rdexp(i));
  endtask

  task automatic do_reset();
    resetn_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    foreach (mreg[i]) mreg[i] = (i >= 4 && i < 12) ? 8'hFF : 8'h00;
  endtask

  // a hang ends the run through the same report
  initial begin
    repeat (50000) @(posedge sys_clk_i);
    chk("watchdog", 1'b0, 1'b1);
    complete_run();
  end

  // main sequence
  initial begin
    seed = 41;
    err_total = 0;
    checks_done = 0;
    {resetn_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {porta_in_i, portb_in_i, portc_in_i, portd_in_i} = 27'h7FFFFFF;
    {peri_out_i, lcd_portc_i, lcd_portd_i} = '0;
    do_reset();
    @(posedge sys_clk_i);
    chk("pins", {portc_oe_n_o, portd_oe_n_o, portc_out_o}, {7'h7F, 4'hF, 7'h7F});
    for (int k = 0; k < 15; k++) if (k != 12) mr(k);
    apb(1'b1, 8'h40, 32'($random(seed)));
    apb(1'b0, 8'h40, 32'h00000000);
    chk("unmapped", rd, 32'h00000000);
    repeat (2) begin
      for (int k = 0; k < 15; k++) if (k != 12) mw(k, 8'($random(seed)));
      for (int k = 0; k < 15; k++) if (k != 12) mr(k);
    end
    // a second reset, then outputs enabled with the data left at its reset value
    do_reset();
    mw(9, 8'h00);
    repeat (2) @(posedge sys_clk_i);
    chk("pc drive", {portc_out_o, portc_oe_n_o}, {7'h7F, 7'h00});
    mw(8, 8'h55);
    apb(1'b1, pcm_pkg::ADDR_BIT_OP, 32'h0000002E);
    apb(1'b1, pcm_pkg::ADDR_BIT_OP, 32'h00000043);
    mreg[8] = 8'h5D;
    mreg[11] = 8'hFE;
    mr(8);
    mr(11);
    mw(11, 8'h00);
    for (int code = 0; code < 4; code++) begin
      peri_out_i <= '0; // peripherals off before the fields change
      mw(8, 8'($random(seed)));
      mw(10, 8'($random(seed)));
      mw(0, 8'(code * 8'h55));
      mw(1, 8'(code * 8'h15));
      mw(2, 8'(code * 8'h55));
      peri_out_i <= 7'($random(seed)) & 7'h6B; // enables low, so a driven pin shows its level
      lcd_portc_i <= 7'($random(seed));
      lcd_portd_i <= 4'($random(seed));
      repeat (2) @(posedge sys_clk_i);
      dat = {4'(mreg[10]), 7'(mreg[8])};
      for (int p = 0; p < 11; p++) begin
        kd = KIND[p][code];
        eo = (kd == 0) ? dat[p] : (kd == 1) ? peri_out_i[PV[p]] : lcd_all[p];
        chk("pin", {an_all[p], oe_all[p], kd < 3 ? out_all[p] : 1'b0}, {kd == 3, kd > 2, kd < 3 ? eo : 1'b0});
      end
    end
    mw(9, 8'hFF); // pins back to inputs before they feed interrupts and serial inputs
    mw(11, 8'hFF);
    for (int k = 0; k < 8; k++) begin
      sel = (k == 0) ? 6'h00 : (k == 1) ? 6'h3F : 6'($random(seed));
      mw(14, 8'(k > 5));
      mw(3, {2'h0, sel});
      {porta_in_i, portb_in_i, portc_in_i, portd_in_i} <= 27'($random(seed));
      repeat (2) @(posedge sys_clk_i);
      if (k > 5) sel = sel & 6'h30;
      chk("source", peri_in_o, {sel[5] ? porta_in_i[2] : portb_in_i[1], sel[4] ? porta_in_i[1] : portb_in_i[0],
        sel[3] ? porta_in_i[3] : portc_in_i[4], sel[2] ? portb_in_i[6] : portc_in_i[5],
        sel[1] ? portb_in_i[5] : portc_in_i[6], sel[0] ? portc_in_i[1] : portd_in_i[1]});
      mr(3);
    end
    // only an enabled pin wakes, and only in the low power mode
    porta_in_i <= 8'hFF;
    mw(13, 8'h04);
    mw(14, 8'h02);
    porta_in_i <= 8'hF7;
    repeat (4) @(posedge sys_clk_i);
    chk("wake", wake_o, 1'b0);
    porta_in_i <= 8'hF3;
    repeat (4) @(posedge sys_clk_i);
    chk("wake", wake_o, 1'b1);
    apb(1'b1, pcm_pkg::ADDR_STATUS, 32'h00000001);
    mw(14, 8'h00);
    porta_in_i <= 8'hFF;
    repeat (2) @(posedge sys_clk_i);
    porta_in_i <= 8'hFB;
    repeat (4) @(posedge sys_clk_i);
    chk("wake", wake_o, 1'b0);
    complete_run();
  end
endmodule // pcm_port_cd_mux_tb
